// *** bench/clock_fail_watchdog_lowpower_bench.sv ***
`define chk(n, e, g) check_val(n, 32'(e), 32'(g))
module clock_fail_watchdog_lowpower_bench
   import clkwd_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, reset = 1'b1, pll_active = 1'b1, osc_present = 1'b1, fail_reset_select = 1'b0;
   logic [15:0] nmi_period = 16'h0020;
   logic nmi_clear, limp_select, nmi_pending, missing_clock_flag, clock_fail_event, device_reset;
   logic wdog_enable = 1'b0, wdog_irq_mode = 1'b0, key_write, wdog_reset_out_n, wdog_wake_irq_n;
   logic [7:0] key_data, wdog_count;
   logic idle_exec = 1'b0, pin_reset_n = 1'b1, enabled_irq = 1'b0, wdog_wake_enable = 1'b1, cpu_wake_irq;
   logic [1:0] lowpower_mode_field = 2'h0;
   logic [5:0] qual_cycles = 6'h04;
   logic [31:0] wake_pin_select = 32'h00000000, gpio_a_in = 32'hffffffff;
   logic kick = 1'b0, clear_on = 1'b0;
   clock_ctrl_type clock_ctrl;
   power_state_type power_state;
   int failures = 0, checked = 0, exp_state, n, k;
   logic [7:0] held;
   logic seen;
   // ==========================================
   // clock, design and partner
   always #50 clk = ~clk;
   clock_fail_watchdog_lowpower u_dut (.clk(clk), .reset(reset), .pll_active(pll_active),
      .osc_present(osc_present), .fail_reset_select(fail_reset_select), .nmi_period(nmi_period),
      .nmi_clear(nmi_clear), .limp_select(limp_select), .nmi_pending(nmi_pending),
      .missing_clock_flag(missing_clock_flag), .clock_fail_event(clock_fail_event),
      .device_reset(device_reset), .wdog_enable(wdog_enable), .wdog_irq_mode(wdog_irq_mode),
      .key_write(key_write), .key_data(key_data), .wdog_reset_out_n(wdog_reset_out_n),
      .wdog_wake_irq_n(wdog_wake_irq_n), .wdog_count(wdog_count), .idle_exec(idle_exec),
      .lowpower_mode_field(lowpower_mode_field), .qual_cycles(qual_cycles),
      .wake_pin_select(wake_pin_select), .gpio_a_in(gpio_a_in), .pin_reset_n(pin_reset_n),
      .enabled_irq(enabled_irq), .wdog_wake_enable(wdog_wake_enable), .cpu_wake_irq(cpu_wake_irq),
      .clock_ctrl(clock_ctrl), .power_state(power_state));
   sw_partner u_sw (.clk(clk), .reset(reset), .kick(kick), .clear_on(clear_on),
      .nmi_pending(nmi_pending), .key_write(key_write), .key_data(key_data), .nmi_clear(nmi_clear));
   // ==========================================
   // checking and closing
   task automatic check_val(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         failures++;
         $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic do_reset();
      reset = 1'b1;
      osc_present = 1'b1;
      repeat (20) @(negedge clk);
      reset = 1'b0;
      exp_state = run_state;
      @(negedge clk);
   endtask
   // mode request; the state follows within two edges
   task automatic enter(input logic [1:0] m);
      lowpower_mode_field = m;
      idle_exec = 1'b1;
      @(negedge clk);
      idle_exec = 1'b0;
      @(negedge clk);
   endtask
   task automatic wait_state(input int lim);
      n = 0;
      while (power_state !== power_state_type'(exp_state) && n < lim)
      begin
         @(negedge clk);
         n++;
      end
      `chk("power_state", exp_state, power_state);
   endtask
   // clock loss: immediate reset or nmi counter, with or without a software answer
   task automatic fail_case(input logic sel, input logic clr);
      do_reset();
      fail_reset_select = sel;
      clear_on = clr;
      wdog_enable = 1'b1;
      nmi_period = 16'(20 + $urandom % 20);
      repeat (4) @(negedge clk);
      osc_present = 1'b0;
      repeat (3) @(posedge clk);
      #1;
      `chk("clock_fail_event", 1, clock_fail_event);
      `chk("limp_select", 1, limp_select);
      `chk("missing_clock_flag", 1, missing_clock_flag);
      `chk("nmi_pending", 1, nmi_pending);
      `chk("device_reset", !sel, device_reset);
      held = wdog_count;
      repeat (10) @(negedge clk);
      `chk("wdog_count", held, wdog_count);
      seen = 1'b0;
      repeat (nmi_period + 10)
      begin
         @(negedge clk);
         seen |= device_reset;
      end
      `chk("nmi_reset", sel & !clr, seen);
      `chk("nmi_pending", !clr, nmi_pending);
   endtask
   // legacy watchdog expiry, in idle when it raises the wake interrupt
   task automatic wd_case(input logic mode);
      do_reset();
      wdog_enable = 1'b1;
      wdog_irq_mode = mode;
      repeat (30) @(negedge clk);
      kick = 1'b1;
      // key pair lands on the next two falling edges; look right after the second
      repeat (2) @(negedge clk);
      @(posedge clk);
      #1;
      `chk("wdog_count", 0, wdog_count);
      kick = 1'b0;
      @(negedge clk);
      if (mode)
      begin
         enter(lpm_idle_code);
         exp_state = idle_state;
         wait_state(4);
      end
      k = 0;
      while ((mode ? wdog_wake_irq_n : wdog_reset_out_n) !== 1'b0 && k < 600)
      begin
         @(negedge clk);
         k++;
      end
      n = 0;
      seen = 1'b0;
      while ((mode ? wdog_wake_irq_n : wdog_reset_out_n) === 1'b0 && n < 1000)
      begin
         @(negedge clk);
         seen |= cpu_wake_irq;
         n++;
      end
      `chk("pulse_cycles", wdog_pulse_cycles, n);
      `chk("cpu_wake_irq", mode, seen);
      exp_state = run_state;
      wait_state(4);
   endtask
   // ==========================================
   // main sequence
   initial
   begin
      void'($urandom(32'hde84b6a8));
      do_reset();
      `chk("wdog_reset_out_n", 1, wdog_reset_out_n);
      for (int m = 0; m < 4; m++)
      begin
         fail_case(m[1], m[0]);
      end
      wd_case(1'b0);
      wd_case(1'b1);
      // idle left by an enabled interrupt
      do_reset();
      enter(lpm_idle_code);
      exp_state = idle_state;
      wait_state(4);
      `chk("clock_ctrl", 4'b1111, clock_ctrl);
      enabled_irq = 1'b1;
      exp_state = run_state;
      wait_state(6);
      enabled_irq = 1'b0;
      // standby woken by a qualified pin only
      qual_cycles = 6'(2 + $urandom % 8);
      k = $urandom % 32;
      wake_pin_select = 32'h1 << k;
      enter(lpm_standby_code);
      exp_state = standby_state;
      wait_state(4);
      `chk("clock_ctrl", 4'b0011, clock_ctrl);
      gpio_a_in[k] = 1'b0;
      @(negedge clk);
      gpio_a_in[k] = 1'b1;
      repeat (20) @(negedge clk);
      `chk("power_state", standby_state, power_state);
      gpio_a_in[k] = 1'b0;
      exp_state = run_state;
      wait_state(qual_cycles + 8);
      `chk("qualified", 1, n >= qual_cycles);
      gpio_a_in[k] = 1'b1;
      // halt refused without watchdog clock, then left by pin reset
      wdog_enable = 1'b0;
      enter({1'b1, 1'($urandom)});
      `chk("power_state", run_state, power_state);
      wdog_enable = 1'b1;
      enter({1'b1, 1'($urandom)});
      exp_state = halt_state;
      wait_state(4);
      `chk("osc_clock_en", 0, clock_ctrl.osc_clock_en);
      `chk("pin_hold", 1, clock_ctrl.pin_hold);
      pin_reset_n = 1'b0;
      exp_state = run_state;
      wait_state(10);
      pin_reset_n = 1'b1;
      // let the released pin reset pass the synchroniser before the next entry
      repeat (3) @(negedge clk);
      // standby left by the watchdog interrupt
      enter(lpm_standby_code);
      exp_state = run_state;
      wait_state(300);
      `chk("cpu_wake_irq", 1, cpu_wake_irq);
      // halt left by the watchdog reset once the interrupt pulse has ended
      wdog_irq_mode = 1'b0;
      enter({1'b1, 1'($urandom)});
      exp_state = halt_state;
      wait_state(4);
      exp_state = run_state;
      wait_state(1000);
      `chk("device_reset", 1, device_reset);
      stop_test();
   end
   // ==========================================
   // hang guard, well beyond the expected run length
   initial
   begin
      #3ms;
      failures++;
      stop_test();
   end
endmodule

// *** bench/sw_partner.sv ***
module sw_partner
   import clkwd_pkg::*;
#(
   parameter int clear_delay = 3
)
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // requests from the bench
   input wire logic kick,
   input wire logic clear_on,
   input wire logic nmi_pending,
   // towards the block
   output logic key_write,
   output logic [7:0] key_data,
   output logic nmi_clear
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================
   // software side
   initial
   begin
      key_write = 1'b0;
      key_data = 8'h00;
      nmi_clear = 1'b0;
   end
   // key pair back to back; an idle bus shows the inverse of the last byte
   always @(posedge kick)
   begin
      @(negedge clk);
      key_write = 1'b1;
      key_data = wdog_key_first;
      @(negedge clk);
      key_data = wdog_key_second;
      @(negedge clk);
      key_write = 1'b0;
      key_data = ~key_data;
   end
   // slow handler: only clears when the bench lets software respond
   always @(posedge nmi_pending)
   begin
      if (clear_on && !reset)
      begin
         repeat (clear_delay) @(negedge clk);
         nmi_clear = 1'b1;
         @(negedge clk);
         nmi_clear = 1'b0;
      end
   end
endmodule

// *** design/clock_fail_watchdog_lowpower.sv ***
// How it works
// - on input clock loss while the pll is active, switch to limp clock
// - limp entry latches a pending non-maskable clock-fail interrupt
// - reset select chooses immediate reset or arming the nmi watchdog counter
// - clock failure sets a readable missing-clock flag
// - 8-bit up counter at max drives active-low output for 512 cycles
// - key 0x55 then 0xaa clears the watchdog counter
// - watchdog counter holds while limp clock runs
// - in standby only the watchdog runs; its interrupt wakes the block
// - in idle the watchdog interrupt raises a processor interrupt
// - in halt the watchdog wakes the device by full reset
// - mode 00 is idle: clocks on, any interrupt or pin reset exits
// - mode 01 is standby: cpu and system clocks stop, oscillator runs
// - mode 1x is halt: oscillator and pll stop; needs watchdog clock
// - selected port a pins wake standby after qualification cycles
// - halt exits by watchdog, pin reset or selected port a pin
// - output pins keep their state during any low-power mode
module clock_fail_watchdog_lowpower
   import clkwd_pkg::*;
#(
   parameter int nmi_width = nmi_count_width
)
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // clock supervision
   input wire logic pll_active,
   input wire logic osc_present,
   input wire logic fail_reset_select,
   input wire logic [15:0] nmi_period,
   input wire logic nmi_clear,
   output logic limp_select,
   output logic nmi_pending,
   output logic missing_clock_flag,
   output logic clock_fail_event,
   output logic device_reset,
   // legacy watchdog
   input wire logic wdog_enable,
   input wire logic wdog_irq_mode,
   input wire logic key_write,
   input wire logic [7:0] key_data,
   output logic wdog_reset_out_n,
   output logic wdog_wake_irq_n,
   output logic [7:0] wdog_count,
   // low-power control
   input wire logic idle_exec,
   input wire logic [1:0] lowpower_mode_field,
   input wire logic [5:0] qual_cycles,
   input wire logic [31:0] wake_pin_select,
   input wire logic [31:0] gpio_a_in,
   input wire logic pin_reset_n,
   input wire logic enabled_irq,
   input wire logic wdog_wake_enable,
   output logic cpu_wake_irq,
   output clock_ctrl_type clock_ctrl,
   output power_state_type power_state
);
   typedef struct packed
   {
      logic osc_s1;
      logic osc_s2;
      logic rst_s1;
      logic rst_s2;
      logic [31:0] gpio_s1;
      logic [31:0] gpio_s2;
      logic limp;
      logic pend;
      logic missing;
      logic fail_pulse;
      logic [15:0] nmi_cnt;
      logic dev_rst;
      logic wake_irq;
      power_state_type pstate;
   } top_state_type;

   top_state_type s_q, s_d;
   logic wd_rst_n;
   logic wd_irq_n;
   logic qual_wake;
   logic pin_rst;
   logic wd_irq;

   // ==============================================================
   // legacy watchdog
   wdog_core #(
      .pulse_cycles(wdog_pulse_cycles)
   ) u_wdog (
      .clk(clk),
      .reset(reset),
      .enable(wdog_enable),
      .limp_active(s_q.limp),
      .key_write(key_write),
      .key_data(key_data),
      .irq_mode(wdog_irq_mode),
      .wdog_reset_out_n(wd_rst_n),
      .wdog_wake_irq_n(wd_irq_n),
      .count(wdog_count)
   );

   // ==============================================================
   // gpio wake qualification, only armed in standby or halt
   wake_qualifier u_qual (
      .clk(clk),
      .reset(reset),
      .pins_sync(s_q.gpio_s2),
      .select(wake_pin_select),
      .qual_cycles(qual_cycles),
      .armed(s_q.pstate == standby_state || s_q.pstate == halt_state),
      .wake(qual_wake)
   );

   assign pin_rst = !s_q.rst_s2;
   assign wd_irq = !wd_irq_n;

   // ==============================================================
   // supervision and power state
   always_comb
   begin
      // pins cross into this domain through two flops
      s_d = s_q;
      s_d.osc_s1 = osc_present;
      s_d.osc_s2 = s_q.osc_s1;
      s_d.rst_s1 = pin_reset_n;
      s_d.rst_s2 = s_q.rst_s1;
      s_d.gpio_s1 = gpio_a_in;
      s_d.gpio_s2 = s_q.gpio_s1;
      s_d.fail_pulse = 1'b0;
      s_d.dev_rst = 1'b0;
      s_d.wake_irq = 1'b0;

      // clock loss detection; limp stays until reset
      if (pll_active && !s_q.osc_s2 && !s_q.limp)
      begin
         s_d.limp = 1'b1;
         s_d.fail_pulse = 1'b1;
         s_d.missing = 1'b1;
         s_d.pend = 1'b1;
         if (!fail_reset_select)
            s_d.dev_rst = 1'b1;
      end
      else if (nmi_clear)
      begin
         s_d.pend = 1'b0;
      end

      // nmi counter; a new failure wins over a clear
      if (s_q.pend && !nmi_clear && fail_reset_select)
      begin
         if (s_q.nmi_cnt >= nmi_period)
         begin
            s_d.dev_rst = 1'b1;
            s_d.nmi_cnt = '0;
         end
         else
            s_d.nmi_cnt = s_q.nmi_cnt + 16'h0001;
      end
      else if (!s_q.pend || nmi_clear)
         s_d.nmi_cnt = '0;

      // low-power state machine
      unique case (s_q.pstate)
         run_state:
         begin
            if (idle_exec)
            begin
               if (lowpower_mode_field[lpm_halt_bit] && wdog_enable)
                  s_d.pstate = halt_state;
               else if (lowpower_mode_field == lpm_standby_code)
                  s_d.pstate = standby_state;
               else if (lowpower_mode_field == lpm_idle_code)
                  s_d.pstate = idle_state;
            end
         end
         idle_state:
         begin
            if (enabled_irq || wd_irq || pin_rst)
               s_d.pstate = run_state;
            if (wd_irq)
               s_d.wake_irq = 1'b1;
         end
         standby_state:
         begin
            if ((wd_irq && wdog_wake_enable) || qual_wake || pin_rst)
            begin
               s_d.pstate = run_state;
               s_d.wake_irq = 1'b1;
            end
         end
         halt_state:
         begin
            if (!wd_rst_n)
            begin
               s_d.pstate = run_state;
               s_d.dev_rst = 1'b1;
            end
            else if (qual_wake || pin_rst)
               s_d.pstate = run_state;
         end
      endcase
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         s_q <= '0;
         s_q.osc_s1 <= 1'b1;
         s_q.osc_s2 <= 1'b1;
         s_q.rst_s1 <= 1'b1;
         s_q.rst_s2 <= 1'b1;
         s_q.gpio_s1 <= '1;
         s_q.gpio_s2 <= '1;
         s_q.pstate <= run_state;
      end
      else
         s_q <= s_d;
   end

   // ==============================================================
   // outputs
   assign limp_select = s_q.limp;
   assign nmi_pending = s_q.pend;
   assign missing_clock_flag = s_q.missing;
   assign clock_fail_event = s_q.fail_pulse;
   assign device_reset = s_q.dev_rst || !wd_rst_n;
   assign wdog_reset_out_n = wd_rst_n;
   assign wdog_wake_irq_n = wd_irq_n;
   assign cpu_wake_irq = s_q.wake_irq;
   assign power_state = s_q.pstate;

   // clocks gated per mode; pins frozen in every low-power mode
   always_comb
   begin
      clock_ctrl.cpu_clock_en = (s_q.pstate == run_state || s_q.pstate == idle_state);
      clock_ctrl.system_clock_en = clock_ctrl.cpu_clock_en;
      clock_ctrl.osc_clock_en = (s_q.pstate != halt_state);
      clock_ctrl.pin_hold = (s_q.pstate != run_state);
   end

   // ==============================================================
   // checks
   a_fail_flags: assert property (@(posedge clk) disable iff (reset)
      clock_fail_event |-> limp_select && nmi_pending && missing_clock_flag)
      else $error("clock fail without flags");
   a_immediate_reset: assert property (@(posedge clk) disable iff (reset)
      pll_active && !s_q.osc_s2 && !s_q.limp && !fail_reset_select |=> device_reset)
      else $error("no immediate reset on clock fail");
   a_limp_sticky: assert property (@(posedge clk) disable iff (reset)
      limp_select |=> limp_select)
      else $error("limp clock dropped");
   a_nmi_clear: assert property (@(posedge clk) disable iff (reset)
      nmi_pending && nmi_clear && !clock_fail_event |=> s_q.nmi_cnt == 16'h0000)
      else $error("nmi counter not cleared");
   a_standby_gating: assert property (@(posedge clk) disable iff (reset)
      power_state == standby_state |-> !clock_ctrl.cpu_clock_en && clock_ctrl.osc_clock_en)
      else $error("standby clock gating wrong");
   a_halt_needs_wd: assert property (@(posedge clk) disable iff (reset)
      power_state == run_state ##1 power_state == halt_state |-> $past(wdog_enable))
      else $error("halt entered without watchdog clock");
   a_pin_hold: assert property (@(posedge clk) disable iff (reset)
      power_state != run_state |-> clock_ctrl.pin_hold)
      else $error("pins not held in low power");
   a_idle_wd_wake: assert property (@(posedge clk) disable iff (reset)
      power_state == idle_state && wd_irq |=> cpu_wake_irq && power_state == run_state)
      else $error("watchdog did not wake idle");
   c_fail: cover property (@(posedge clk) disable iff (reset) clock_fail_event);
   c_standby_exit: cover property (@(posedge clk) disable iff (reset)
      power_state == standby_state ##1 power_state == run_state);
   c_halt_exit: cover property (@(posedge clk) disable iff (reset)
      power_state == halt_state ##1 power_state == run_state);
   c_idle_wd_wake: cover property (@(posedge clk) disable iff (reset)
      power_state == idle_state ##1 cpu_wake_irq);

   // ==============================================================
   // flag and nmi counter checks
   a_missing_sticky: assert property (@(posedge clk) disable iff (reset)
      missing_clock_flag |=> missing_clock_flag)
      else $error("missing clock flag dropped");
   a_pending_holds: assert property (@(posedge clk) disable iff (reset)
      nmi_pending && !nmi_clear |=> nmi_pending)
      else $error("pending nmi lost without a clear");
   a_fail_single: assert property (@(posedge clk) disable iff (reset)
      clock_fail_event |=> !clock_fail_event)
      else $error("clock fail event too long");
   a_limp_needs_pll: assert property (@(posedge clk) disable iff (reset)
      $rose(limp_select) |-> $past(pll_active))
      else $error("limp clock without pll in use");
   // the overflow reset is the only way out when software never answers
   a_nmi_overflow: assert property (@(posedge clk) disable iff (reset)
      nmi_pending && fail_reset_select && !nmi_clear && s_q.nmi_cnt >= nmi_period |=> device_reset)
      else $error("nmi overflow gave no reset");
   a_nmi_idle_zero: assert property (@(posedge clk) disable iff (reset)
      !nmi_pending |=> s_q.nmi_cnt == 16'h0000)
      else $error("nmi counter ran with nothing pending");

   // ==============================================================
   // power state checks
   a_idle_entry: assert property (@(posedge clk) disable iff (reset)
      power_state == run_state && idle_exec && lowpower_mode_field == lpm_idle_code
      |=> power_state == idle_state)
      else $error("idle not entered");
   a_standby_entry: assert property (@(posedge clk) disable iff (reset)
      power_state == run_state && idle_exec && lowpower_mode_field == lpm_standby_code
      |=> power_state == standby_state)
      else $error("standby not entered");
   a_halt_entry: assert property (@(posedge clk) disable iff (reset)
      power_state == run_state && idle_exec && lowpower_mode_field[lpm_halt_bit] && wdog_enable
      |=> power_state == halt_state)
      else $error("halt not entered");
   a_halt_refused: assert property (@(posedge clk) disable iff (reset)
      power_state == run_state && idle_exec && lowpower_mode_field[lpm_halt_bit] && !wdog_enable
      |=> power_state == run_state)
      else $error("halt entered with watchdog stopped");
   a_idle_irq_exit: assert property (@(posedge clk) disable iff (reset)
      power_state == idle_state && enabled_irq |=> power_state == run_state)
      else $error("interrupt did not leave idle");
   a_standby_wd_wake: assert property (@(posedge clk) disable iff (reset)
      power_state == standby_state && !wdog_wake_irq_n && wdog_wake_enable
      |=> power_state == run_state && cpu_wake_irq)
      else $error("watchdog did not wake standby");
   a_standby_pin_wake: assert property (@(posedge clk) disable iff (reset)
      power_state == standby_state && qual_wake |=> power_state == run_state && cpu_wake_irq)
      else $error("qualified pin did not wake standby");
   a_halt_wd_reset: assert property (@(posedge clk) disable iff (reset)
      power_state == halt_state && !wdog_reset_out_n |=> power_state == run_state && device_reset)
      else $error("watchdog reset did not leave halt");
   // a stray halt exit would release frozen pins with no cause
   a_halt_exit_cause: assert property (@(posedge clk) disable iff (reset)
      power_state == halt_state ##1 power_state == run_state
      |-> $past(qual_wake) || $past(pin_rst) || !$past(wdog_reset_out_n))
      else $error("halt left without a wake source");
   a_pin_reset_exit: assert property (@(posedge clk) disable iff (reset)
      power_state != run_state && pin_rst |=> power_state == run_state)
      else $error("pin reset did not leave low power");
   a_idle_clocks: assert property (@(posedge clk) disable iff (reset)
      power_state == idle_state |-> clock_ctrl.cpu_clock_en && clock_ctrl.system_clock_en && clock_ctrl.osc_clock_en)
      else $error("clocks stopped in idle");
   a_halt_osc_off: assert property (@(posedge clk) disable iff (reset)
      power_state == halt_state |-> !clock_ctrl.osc_clock_en && !clock_ctrl.cpu_clock_en)
      else $error("clocks running in halt");
   a_run_pins_free: assert property (@(posedge clk) disable iff (reset)
      power_state == run_state |-> !clock_ctrl.pin_hold)
      else $error("pins held while running");
   a_wake_single: assert property (@(posedge clk) disable iff (reset)
      cpu_wake_irq |=> !cpu_wake_irq)
      else $error("wake interrupt longer than one cycle");
endmodule

// *** design/wake_qualifier.sv ***
module wake_qualifier
   import clkwd_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // wake pins, already synchronised
   input wire logic [31:0] pins_sync,
   input wire logic [31:0] select,
   input wire logic [5:0] qual_cycles,
   input wire logic armed,
   // result
   output logic wake
);
   typedef struct packed
   {
      logic [5:0] cnt;
      logic hit;
   } qual_state_type;

   qual_state_type s_q, s_d;
   logic any_low;

   // a selected pin held low counts; a bounce restarts the count
   assign any_low = |(~pins_sync & select);

   always_comb
   begin
      s_d = s_q;
      s_d.hit = 1'b0;
      if (!armed || !any_low)
         s_d.cnt = '0;
      else if (s_q.cnt >= qual_cycles)
         s_d.hit = 1'b1;
      else
         s_d.cnt = s_q.cnt + 6'h01;
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign wake = s_q.hit;

   a_qual_needs_low: assert property (@(posedge clk) disable iff (reset)
      wake |-> $past(any_low) && $past(armed))
      else $error("wake without a held low pin");
endmodule

// *** design/wdog_core.sv ***
module wdog_core
   import clkwd_pkg::*;
#(
   parameter int pulse_cycles = wdog_pulse_cycles
)
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // control
   input wire logic enable,
   input wire logic limp_active,
   input wire logic key_write,
   input wire logic [7:0] key_data,
   input wire logic irq_mode,
   // outputs
   output logic wdog_reset_out_n,
   output logic wdog_wake_irq_n,
   output logic [7:0] count
);
   typedef struct packed
   {
      logic [7:0] cnt;
      logic key_armed;
      logic [9:0] pulse;
      logic pulse_on;
      logic mode;
   } wdog_state_type;

   wdog_state_type s_q, s_d;

   // ==============================================================
   // counter, key sequence and output pulse
   always_comb
   begin
      s_d = s_q;
      if (key_write)
      begin
         if (key_data == wdog_key_first)
            s_d.key_armed = 1'b1;
         else if (key_data == wdog_key_second && s_q.key_armed)
         begin
            s_d.cnt = '0;
            s_d.key_armed = 1'b0;
         end
         else
            s_d.key_armed = 1'b0;
      end
      else if (enable && !limp_active && !s_q.pulse_on)
      begin
         if (s_q.cnt == wdog_count_max)
         begin
            s_d.pulse_on = 1'b1;
            s_d.pulse = wdog_pulse_reset;
            s_d.mode = irq_mode;
            s_d.cnt = '0;
         end
         else
            s_d.cnt = s_q.cnt + 8'h01;
      end
      if (s_q.pulse_on)
      begin
         if (s_q.pulse == 10'(pulse_cycles - 1))
            s_d.pulse_on = 1'b0;
         else
            s_d.pulse = s_q.pulse + 10'h001;
      end
      if (!enable)
      begin
         s_d.cnt = '0;
      end
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   // active low pulses, one of two outputs by mode
   assign wdog_reset_out_n = !(s_q.pulse_on && !s_q.mode);
   assign wdog_wake_irq_n = !(s_q.pulse_on && s_q.mode);
   assign count = s_q.cnt;

   // ==============================================================
   // checks
   a_pulse_width: assert property (@(posedge clk) disable iff (reset)
      $rose(s_q.pulse_on) |-> s_q.pulse_on [*8])
      else $error("watchdog pulse ended too early");
   a_key_clears: assert property (@(posedge clk) disable iff (reset)
      key_write && key_data == wdog_key_second && s_q.key_armed |=> count == 8'h00)
      else $error("key sequence did not clear counter");
   a_limp_hold: assert property (@(posedge clk) disable iff (reset)
      limp_active && !key_write && enable && !s_q.pulse_on |=> $stable(count))
      else $error("watchdog counted in limp mode");
   c_pulse_fires: cover property (@(posedge clk) disable iff (reset) $rose(s_q.pulse_on));
endmodule

// *** inc/clkwd_pkg.sv ***
package clkwd_pkg;
   // ==============================================================
   // low-power mode field
   localparam logic [1:0] lpm_idle_code = 2'h0;
   localparam logic [1:0] lpm_standby_code = 2'h1;
   localparam int lpm_halt_bit = 1;
   // ==============================================================
   // legacy watchdog
   localparam int wdog_count_width = 8;
   localparam logic [7:0] wdog_count_max = 8'hff;
   localparam logic [7:0] wdog_key_first = 8'h55;
   localparam logic [7:0] wdog_key_second = 8'haa;
   localparam int wdog_pulse_cycles = 512;
   localparam logic [9:0] wdog_pulse_reset = 10'h000;
   // ==============================================================
   // nmi watchdog and qualification
   localparam int nmi_count_width = 16;
   localparam logic [15:0] nmi_period_reset = 16'hffff;
   localparam int qual_count_width = 6;
   localparam int wake_pin_count = 32;

   typedef enum logic [1:0]
   {
      run_state = 2'b00,
      idle_state = 2'b01,
      standby_state = 2'b10,
      halt_state = 2'b11
   } power_state_type;

   // clock gating outputs travel together
   typedef struct packed
   {
      logic cpu_clock_en;
      logic system_clock_en;
      logic osc_clock_en;
      logic pin_hold;
   } clock_ctrl_type;
endpackage
